// >>> design/cbu_pkg.sv
// Contract
// - Target answers 8-bit write address 0xAA and read address 0xAB.
// - Multi-byte writes store at incrementing locations; single-byte writes also work.
// - Enter-config subcommand, low byte first, starts transition into update state.
// - Flags bit 4 sets within one second once update state is active.
// - Writing zero to block control location enables block window access.
// - Byte written to subclass-select location picks the data memory subclass.
// - Block-select byte picks which 32-byte block of the subclass is shown.
// - Checksum location reads back checksum of the selected 32-byte block.
// - Selected block appears at 0x40 plus offset modulo 32, read and write.
// - Multi-byte parameters are stored high byte at the lower address.
// - Checksum is 255 minus wrapping byte sum of window 0x40 to 0x5F.
// - Window commits to data memory only when a correct checksum is written.
// - Soft-reset subcommand, low byte first, leaves the configuration update state.
// - Flags bit 4 clears within one second after the exit subcommand.
// - Enter-config sets control status bit and enters update; refused while locked.
// - Commands are two bytes moved in consecutive transfers after a command byte.
`default_nettype none
package cbu_pkg;

  // Bus addresses, 8-bit form
  localparam logic [7:0] ADDR_WR = 8'hAA;
  localparam logic [7:0] ADDR_RD = 8'hAB;

  // Command locations
  localparam logic [7:0] REG_CTRL_LO  = 8'h00;
  localparam logic [7:0] REG_CTRL_HI  = 8'h01;
  localparam logic [7:0] REG_FLAGS_LO = 8'h06;
  localparam logic [7:0] REG_FLAGS_HI = 8'h07;
  localparam logic [7:0] REG_SUBCLASS = 8'h3E;
  localparam logic [7:0] REG_BLOCK    = 8'h3F;
  localparam logic [7:0] REG_WIN_BASE = 8'h40;
  localparam logic [7:0] REG_WIN_LAST = 8'h5F;
  localparam logic [7:0] REG_CKSUM    = 8'h60;
  localparam logic [7:0] REG_ACCESS   = 8'h61;

  // Subcommands
  localparam logic [15:0] CMD_UNLOCK     = 16'h8000;
  localparam logic [15:0] CMD_ENTER      = 16'h0013;
  localparam logic [15:0] CMD_SOFT_RESET = 16'h0042;
  localparam logic [15:0] CMD_LOCK       = 16'h0020;

  // Field positions
  localparam int FLAG_CFG_BIT  = 4;
  localparam int CTRL_CFG_BIT  = 5;
  localparam int CTRL_LOCK_BIT = 13;

  // Field values
  localparam logic [7:0] ACCESS_ENABLE = 8'h00;
  localparam logic [7:0] CKSUM_BASE    = 8'hFF;
  localparam logic [7:0] ACCESS_RST    = 8'hFF;
  localparam logic [7:0] BYTE_ZERO     = 8'h00;

  // Values after reset
  localparam logic RST_LOCKED = 1'b1;

  // Timing
  localparam int CLK_HZ      = 50_000_000;
  localparam int CFG_MAX_MS  = 1000;
  localparam int CFG_DLY_CYC = (CLK_HZ / 1000) * CFG_MAX_MS;
  localparam int TMR_W       = 26;

  // Memory geometry
  localparam int WIN_AW     = 5;
  localparam int DM_AW      = 10;
  localparam int SUB_IDX_W  = 4;
  localparam int IDX_W      = 10;
  localparam logic [WIN_AW-1:0] WIN_LAST_IDX = 5'h1F;
  localparam logic [IDX_W-1:0]  DM_LAST_IDX  = 10'h3FF;

  // One byte written by the host
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } cbu_wr_t;

  // Bus target states
  typedef enum logic [3:0] {
    I_IDLE, I_ADDR, I_ACK_A, I_CMD, I_ACK_C, I_WDAT, I_ACK_W, I_RDAT, I_ACK_R
  } cbu_i2c_st_t;

  // Block engine states
  typedef enum logic [2:0] {
    E_CLEAR, E_LOAD, E_IDLE, E_WRD, E_WUPD, E_COPY
  } cbu_eng_st_t;

endpackage : cbu_pkg
`default_nettype wire

// >>> design/cbu_byte_ram.sv
`timescale 1ns/10ps
`default_nettype none
module cbu_byte_ram import cbu_pkg::*; #(
  parameter int AW = WIN_AW
) (
  // Clock
  input  wire logic          i_ref_clk,
  // Access port
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [7:0]    i_wdata,
  output logic      [7:0]    o_rdata
);

  logic [7:0] mem_q [2**AW];

  // Single port; read data is registered, so callers wait one cycle
  always_ff @(posedge i_ref_clk) begin
    if (i_we) begin
      mem_q[i_addr] <= i_wdata;
    end
    o_rdata <= mem_q[i_addr];
  end

endmodule : cbu_byte_ram
`default_nettype wire

// >>> design/cbu_config_block.sv
`timescale 1ns/10ps
`default_nettype none
module cbu_config_block import cbu_pkg::*; #(
  parameter int P_CFG_DLY_CYC = CFG_DLY_CYC
) (
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  // Two-wire target pins
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_sda,
  output logic      o_sda_oe
);

  // Pin samples
  logic scl_q, scl_p_q, sda_q, sda_p_q;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  // Bus target state
  cbu_i2c_st_t ist_q, ist_d;
  logic [2:0]  cnt_q, cnt_d;
  logic [7:0]  sh_q, sh_d, tx_q, tx_d, ptr_q, ptr_d, rx_byte;
  logic        dir_q, dir_d, ackon_q, ackon_d, oe_q, oe_d, sda_o_q;
  cbu_wr_t     wr_q, wr_d;
  logic        wr_vld_q, wr_vld_d;

  // Control and status state
  logic             locked_q, locked_d, half_q, half_d;
  logic [7:0]       ctrl_lo_q, ctrl_lo_d;
  logic             cfg_stat_q, cfg_stat_d, cfg_flag_q, cfg_flag_d;
  logic             cfg_tgt_q, cfg_tgt_d;
  logic [TMR_W-1:0] tmr_q, tmr_d;
  logic             blk_en_q, blk_en_d;
  logic [7:0]       sub_q, sub_d, blk_q, blk_d, access_q, access_d;
  logic [15:0]      cmd_word, ctrl_stat;
  logic             exec;

  // Block engine state
  cbu_eng_st_t      est_q, est_d;
  logic [IDX_W-1:0] idx_q, idx_d;
  logic             ph_q, ph_d;
  logic [7:0]       sum_q, sum_d;
  cbu_wr_t          pend_q, pend_d;
  logic             eng_idle, sel_ok, in_win;
  logic             wr_sel, wr_win, wr_ck;

  // Memory ports
  logic              dm_we, win_we;
  logic [DM_AW-1:0]  dm_addr;
  logic [WIN_AW-1:0] win_addr;
  logic [7:0]        dm_wd, win_wd, dm_rd, win_rd, rd_byte;

  // Pins are synchronous; one extra stage gives edge history
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      scl_q   <= 1'b1;
      scl_p_q <= 1'b1;
      sda_q   <= 1'b1;
      sda_p_q <= 1'b1;
      sda_o_q <= 1'b0;
    end else begin
      scl_q   <= i_scl;
      scl_p_q <= scl_q;
      sda_q   <= i_sda;
      sda_p_q <= sda_q;
      sda_o_q <= 1'b0;
    end
  end

  // Line events
  assign scl_rise  = scl_q & ~scl_p_q;
  assign scl_fall  = ~scl_q & scl_p_q;
  assign bus_start = scl_q & scl_p_q & sda_p_q & ~sda_q;
  assign bus_stop  = scl_q & scl_p_q & ~sda_p_q & sda_q;
  assign rx_byte   = {sh_q[6:0], sda_q};

  // Status words seen by the host
  always_comb begin
    ctrl_stat                = 16'h0000;
    ctrl_stat[CTRL_CFG_BIT]  = cfg_stat_q;
    ctrl_stat[CTRL_LOCK_BIT] = locked_q;
  end

  assign in_win = (ptr_q >= REG_WIN_BASE) && (ptr_q <= REG_WIN_LAST);

  // Read map; window data come from the prefetched location at the pointer
  always_comb begin
    rd_byte = BYTE_ZERO;
    if (in_win) begin
      rd_byte = win_rd;
    end else begin
      case (ptr_q)
        REG_CTRL_LO:  rd_byte = ctrl_stat[7:0];
        REG_CTRL_HI:  rd_byte = ctrl_stat[15:8];
        REG_FLAGS_LO: rd_byte = {3'h0, cfg_flag_q, 4'h0};
        REG_FLAGS_HI: rd_byte = BYTE_ZERO;
        REG_SUBCLASS: rd_byte = sub_q;
        REG_BLOCK:    rd_byte = blk_q;
        REG_CKSUM:    rd_byte = CKSUM_BASE - sum_q;
        REG_ACCESS:   rd_byte = access_q;
        default:      rd_byte = BYTE_ZERO;
      endcase
    end
  end

  // Bus target: address, command byte, then data bytes each way
  always_comb begin
    ist_d    = ist_q;
    cnt_d    = cnt_q;
    sh_d     = sh_q;
    tx_d     = tx_q;
    ptr_d    = ptr_q;
    dir_d    = dir_q;
    ackon_d  = ackon_q;
    oe_d     = oe_q;
    wr_d     = wr_q;
    wr_vld_d = 1'b0;
    if (bus_start) begin
      ist_d   = I_ADDR;
      cnt_d   = 3'h0;
      oe_d    = 1'b0;
      ackon_d = 1'b0;
    end else if (bus_stop) begin
      ist_d   = I_IDLE;
      oe_d    = 1'b0;
      ackon_d = 1'b0;
    end else begin
      case (ist_q)
        I_ADDR, I_CMD, I_WDAT: begin
          if (scl_rise) begin
            sh_d  = rx_byte;
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
              if (ist_q == I_ADDR) begin
                if (rx_byte == ADDR_WR) begin
                  dir_d = 1'b0;
                  ist_d = I_ACK_A;
                end else if (rx_byte == ADDR_RD) begin
                  dir_d = 1'b1;
                  ist_d = I_ACK_A;
                end else begin
                  ist_d = I_IDLE;
                end
              end else if (ist_q == I_CMD) begin
                ptr_d = rx_byte;
                ist_d = I_ACK_C;
              end else begin
                wr_d     = '{addr: ptr_q, data: rx_byte};
                wr_vld_d = 1'b1;
                ptr_d    = ptr_q + 8'h01;
                ist_d    = I_ACK_W;
              end
            end
          end
        end
        I_ACK_A, I_ACK_C, I_ACK_W: begin
          if (scl_fall) begin
            if (!ackon_q) begin
              oe_d    = 1'b1;
              ackon_d = 1'b1;
            end else begin
              ackon_d = 1'b0;
              cnt_d   = 3'h0;
              if (ist_q == I_ACK_A && dir_q) begin
                tx_d  = rd_byte;
                oe_d  = ~rd_byte[7];
                ist_d = I_RDAT;
              end else begin
                oe_d  = 1'b0;
                ist_d = (ist_q == I_ACK_A) ? I_CMD : I_WDAT;
              end
            end
          end
        end
        I_RDAT: begin
          if (scl_fall) begin
            if (cnt_q == 3'h7) begin
              oe_d  = 1'b0;
              ist_d = I_ACK_R;
            end else begin
              cnt_d = cnt_q + 3'h1;
              tx_d  = {tx_q[6:0], 1'b0};
              oe_d  = ~tx_q[6];
            end
          end
        end
        I_ACK_R: begin
          if (scl_rise) begin
            if (sda_q) begin
              ist_d = I_IDLE;                       // Controller said stop
            end else begin
              ptr_d   = ptr_q + 8'h01;
              ackon_d = 1'b1;
            end
          end else if (scl_fall && ackon_q) begin
            tx_d    = rd_byte;
            oe_d    = ~rd_byte[7];
            cnt_d   = 3'h0;
            ackon_d = 1'b0;
            ist_d   = I_RDAT;
          end
        end
        default: ist_d = I_IDLE;
      endcase
    end
  end

  // Bus target registers
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ist_q    <= I_IDLE;
      cnt_q    <= 3'h0;
      sh_q     <= BYTE_ZERO;
      tx_q     <= BYTE_ZERO;
      ptr_q    <= BYTE_ZERO;
      dir_q    <= 1'b0;
      ackon_q  <= 1'b0;
      oe_q     <= 1'b0;
      wr_q     <= '0;
      wr_vld_q <= 1'b0;
    end else begin
      ist_q    <= ist_d;
      cnt_q    <= cnt_d;
      sh_q     <= sh_d;
      tx_q     <= tx_d;
      ptr_q    <= ptr_d;
      dir_q    <= dir_d;
      ackon_q  <= ackon_d;
      oe_q     <= oe_d;
      wr_q     <= wr_d;
      wr_vld_q <= wr_vld_d;
    end
  end

  // Write qualifiers shared by control and engine
  assign eng_idle = (est_q == E_IDLE);
  assign sel_ok   = ~locked_q & blk_en_q;
  assign wr_sel   = wr_vld_q & sel_ok & eng_idle &
                    (wr_q.addr == REG_SUBCLASS || wr_q.addr == REG_BLOCK);
  assign wr_win   = wr_vld_q & sel_ok & eng_idle &
                    (wr_q.addr >= REG_WIN_BASE) &&
                    (wr_q.addr <= REG_WIN_LAST);
  assign wr_ck    = wr_vld_q & sel_ok & eng_idle &
                    (wr_q.addr == REG_CKSUM);
  assign exec     = wr_vld_q & (wr_q.addr == REG_CTRL_HI);
  assign cmd_word = {wr_q.data, ctrl_lo_q};  // Low byte lands first

  // Subcommands, lock state and the slow mode-change timer
  always_comb begin
    locked_d   = locked_q;
    half_d     = half_q;
    ctrl_lo_d  = ctrl_lo_q;
    cfg_stat_d = cfg_stat_q;
    cfg_flag_d = cfg_flag_q;
    cfg_tgt_d  = cfg_tgt_q;
    tmr_d      = tmr_q;
    blk_en_d   = blk_en_q;
    sub_d      = sub_q;
    blk_d      = blk_q;
    access_d   = access_q;
    // The flag follows the status bit only after the delay runs out
    if (tmr_q != '0) begin
      tmr_d = tmr_q - 1'b1;
      if (tmr_q == TMR_W'(1)) begin
        cfg_flag_d = cfg_tgt_q;
      end
    end
    if (wr_vld_q) begin
      if (wr_q.addr == REG_CTRL_LO) begin
        ctrl_lo_d = wr_q.data;
      end else if (wr_q.addr != REG_CTRL_HI) begin
        half_d = 1'b0;
      end
      if (!locked_q && wr_q.addr == REG_ACCESS) begin
        access_d = wr_q.data;
        blk_en_d = (wr_q.data == ACCESS_ENABLE);
      end
    end
    if (wr_sel && wr_q.addr == REG_SUBCLASS) begin
      sub_d = wr_q.data;
    end
    if (wr_sel && wr_q.addr == REG_BLOCK) begin
      blk_d = wr_q.data;
    end
    if (exec) begin
      if (cmd_word == CMD_UNLOCK) begin
        // Second key must follow the first with nothing else written
        if (half_q) begin
          locked_d = 1'b0;
          half_d   = 1'b0;
        end else begin
          half_d = 1'b1;
        end
      end else begin
        half_d = 1'b0;
        case (cmd_word)
          CMD_ENTER: begin
            if (!locked_q && !cfg_stat_q) begin
              cfg_stat_d = 1'b1;
              cfg_tgt_d  = 1'b1;
              tmr_d      = TMR_W'(P_CFG_DLY_CYC);
            end
          end
          CMD_SOFT_RESET: begin
            if (!locked_q && cfg_stat_q) begin
              cfg_stat_d = 1'b0;
              cfg_tgt_d  = 1'b0;
              tmr_d      = TMR_W'(P_CFG_DLY_CYC);
            end
          end
          CMD_LOCK: begin
            locked_d = 1'b1;
            blk_en_d = 1'b0;
          end
          default: ;
        endcase
      end
    end
  end

  // Control registers
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      locked_q   <= RST_LOCKED;
      half_q     <= 1'b0;
      ctrl_lo_q  <= BYTE_ZERO;
      cfg_stat_q <= 1'b0;
      cfg_flag_q <= 1'b0;
      cfg_tgt_q  <= 1'b0;
      tmr_q      <= '0;
      blk_en_q   <= 1'b0;
      sub_q      <= BYTE_ZERO;
      blk_q      <= BYTE_ZERO;
      access_q   <= ACCESS_RST;
    end else begin
      locked_q   <= locked_d;
      half_q     <= half_d;
      ctrl_lo_q  <= ctrl_lo_d;
      cfg_stat_q <= cfg_stat_d;
      cfg_flag_q <= cfg_flag_d;
      cfg_tgt_q  <= cfg_tgt_d;
      tmr_q      <= tmr_d;
      blk_en_q   <= blk_en_d;
      sub_q      <= sub_d;
      blk_q      <= blk_d;
      access_q   <= access_d;
    end
  end

  // Block engine: two cycles per loaded or copied byte because memory reads are registered; clearing takes one
  always_comb begin
    est_d    = est_q;
    idx_d    = idx_q;
    ph_d     = ph_q;
    sum_d    = sum_q;
    pend_d   = pend_q;
    dm_we    = 1'b0;
    dm_wd    = BYTE_ZERO;
    dm_addr  = {sub_q[SUB_IDX_W-1:0], blk_q[0], idx_q[WIN_AW-1:0]};
    win_we   = 1'b0;
    win_wd   = BYTE_ZERO;
    win_addr = ptr_q[WIN_AW-1:0];
    case (est_q)
      E_CLEAR: begin
        dm_we   = 1'b1;
        dm_addr = idx_q;
        idx_d   = idx_q + 1'b1;
        if (idx_q == DM_LAST_IDX) begin
          est_d = E_LOAD;
          idx_d = '0;
          ph_d  = 1'b0;
          sum_d = BYTE_ZERO;
        end
      end
      E_LOAD: begin
        win_addr = idx_q[WIN_AW-1:0];
        ph_d     = ~ph_q;
        if (ph_q) begin
          win_we = 1'b1;
          win_wd = dm_rd;
          sum_d  = sum_q + dm_rd;
          idx_d  = idx_q + 1'b1;
          if (idx_q[WIN_AW-1:0] == WIN_LAST_IDX) begin
            est_d = E_IDLE;
          end
        end
      end
      E_IDLE: begin
        if (wr_sel) begin
          est_d = E_LOAD;
          idx_d = '0;
          ph_d  = 1'b0;
          sum_d = BYTE_ZERO;
        end else if (wr_win) begin
          pend_d = wr_q;
          est_d  = E_WRD;
        end else if (wr_ck) begin
          idx_d = '0;
          ph_d  = 1'b0;
          if (wr_q.data == CKSUM_BASE - sum_q) begin
            est_d = E_COPY;
          end else begin
            est_d = E_LOAD;
            sum_d = BYTE_ZERO;
          end
        end
      end
      E_WRD: begin
        win_addr = pend_q.addr[WIN_AW-1:0];
        est_d    = E_WUPD;
      end
      E_WUPD: begin
        // Running sum keeps the read-back checksum current after each edit
        win_addr = pend_q.addr[WIN_AW-1:0];
        win_we   = 1'b1;
        win_wd   = pend_q.data;
        sum_d    = sum_q - win_rd + pend_q.data;
        est_d    = E_IDLE;
      end
      E_COPY: begin
        win_addr = idx_q[WIN_AW-1:0];
        ph_d     = ~ph_q;
        if (ph_q) begin
          dm_we = 1'b1;
          dm_wd = win_rd;
          idx_d = idx_q + 1'b1;
          if (idx_q[WIN_AW-1:0] == WIN_LAST_IDX) begin
            est_d = E_IDLE;
          end
        end
      end
      default: est_d = E_IDLE;
    endcase
  end

  // Engine registers; reset clears data memory before the first load
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      est_q  <= E_CLEAR;
      idx_q  <= '0;
      ph_q   <= 1'b0;
      sum_q  <= BYTE_ZERO;
      pend_q <= '0;
    end else begin
      est_q  <= est_d;
      idx_q  <= idx_d;
      ph_q   <= ph_d;
      sum_q  <= sum_d;
      pend_q <= pend_d;
    end
  end

  // Data memory, indexed by subclass low bits, block bit and offset
  cbu_byte_ram #(.AW(DM_AW)) u_dm (
    .i_ref_clk (i_ref_clk),
    .i_we      (dm_we),
    .i_addr    (dm_addr),
    .i_wdata   (dm_wd),
    .o_rdata   (dm_rd)
  );

  // Editing window of one block
  cbu_byte_ram #(.AW(WIN_AW)) u_win (
    .i_ref_clk (i_ref_clk),
    .i_we      (win_we),
    .i_addr    (win_addr),
    .i_wdata   (win_wd),
    .o_rdata   (win_rd)
  );

  // Open-drain data pin: level is always low, enable pulls the line
  assign o_sda    = sda_o_q;
  assign o_sda_oe = oe_q;

endmodule : cbu_config_block
`default_nettype wire

// >>> sim/cbu_config_block_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module cbu_config_block_assertions import cbu_pkg::*; #(
  parameter int P_CFG_DLY_CYC = CFG_DLY_CYC
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Two-wire pins
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda,
  input wire logic o_sda_oe
);
  logic       scl_q, sda_q, first_q, rd_q;
  logic [3:0] bit_q, fall_q;
  logic [7:0] sh_q;
  logic       rise_w, fall_w, stop_w, start_w;

  // Bus events decoded straight from the resolved pins
  assign rise_w  = ~scl_q & i_scl;
  assign fall_w  = scl_q & ~i_scl;
  assign start_w = scl_q & i_scl & sda_q & ~i_sda;
  assign stop_w  = scl_q & i_scl & ~sda_q & i_sda;

  // Bit count per byte; 8 marks the ninth clock, the answer slot
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      bit_q   <= 4'h0;
      first_q <= 1'b0;
      rd_q    <= 1'b0;
      sh_q    <= 8'h00;
      fall_q  <= 4'hF;
    end else begin
      scl_q  <= i_scl;
      sda_q  <= i_sda;
      fall_q <= fall_w ? 4'h0 : (fall_q == 4'hF ? fall_q : fall_q + 4'h1);
      if (start_w) begin
        bit_q   <= 4'h0;
        first_q <= 1'b1;
      end else if (rise_w && bit_q == 4'h8) begin
        bit_q   <= 4'h0;
        first_q <= 1'b0;
        rd_q    <= first_q ? sh_q[0] : rd_q;
      end else if (rise_w) begin
        bit_q <= bit_q + 4'h1;
        sh_q  <= {sh_q[6:0], i_sda};
      end
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  sequence s_ninth_rise;
    rise_w && bit_q == 4'h8;
  endsequence
  sequence s_write_fall;
    fall_w && bit_q == 4'h0 && !rd_q;
  endsequence

  a_open_drain_low: assert property (o_sda == 1'b0)
    else $error("data pin driven high");
  a_addr_ack_match: assert property (s_ninth_rise ##0 first_q |->
    o_sda_oe == (sh_q == ADDR_WR || sh_q == ADDR_RD))
    else $error("address answer wrong");
  a_write_byte_ack: assert property (s_ninth_rise ##0 (!first_q && !rd_q)
    |-> o_sda_oe)
    else $error("written byte not acknowledged");
  a_read_ack_free: assert property (s_ninth_rise ##0 (!first_q && rd_q)
    |-> !o_sda_oe)
    else $error("host answer slot not released");
  a_ack_release: assert property (s_write_fall |-> ##[1:4] !o_sda_oe)
    else $error("acknowledge held too long");
  a_stop_release: assert property (stop_w |-> ##[1:4] !o_sda_oe)
    else $error("line held after stop");
  a_oe_after_fall: assert property ($rose(o_sda_oe) |-> fall_q <= 4'h4)
    else $error("data line pulled away from clock fall");
  a_oe_stable_high: assert property ($rose(i_scl) |->
    ##1 $stable(o_sda_oe) [*4])
    else $error("data line moved while clock high");
endmodule : cbu_config_block_assertions

bind cbu_config_block cbu_config_block_assertions #(
  .P_CFG_DLY_CYC(P_CFG_DLY_CYC)
) u_cbu_config_block_assertions (
  .i_ref_clk(i_ref_clk),
  .i_rst    (i_rst),
  .i_scl    (i_scl),
  .i_sda    (i_sda),
  .o_sda    (o_sda),
  .o_sda_oe (o_sda_oe)
);
`default_nettype wire

// >>> sim/cbu_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module cbu_host_model import cbu_pkg::*; (
  // Clock
  input  wire logic i_ref_clk,
  // Resolved data line
  input  wire logic i_sda,
  // Host drive; the data line is pulled low only, never driven high
  output logic      o_scl,
  output logic      o_sda_low
);
  int         h     = 12;      // Half bit in clocks; raise it for a slow host
  int         nacks = 0;
  logic [7:0] adr   = ADDR_WR;

  initial begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end

  task automatic tk(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask : tk

  // One clock; data set half a phase before the rise for setup and hold
  task automatic bit_x(input logic b, output logic s);
    o_sda_low = ~b;
    tk(h / 2);
    o_scl = 1'b1;
    tk(h / 2);
    s = i_sda;
    tk(h / 2);
    o_scl = 1'b0;
    tk(h / 2);
  endtask : bit_x

  task automatic xfer(input logic [7:0] tx, input logic rel,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
    bit_x(rel, ack);
    ack = ~ack;
  endtask : xfer

  task automatic start();
    o_sda_low = 1'b0;
    tk(h);
    o_scl = 1'b1;
    tk(h);
    o_sda_low = 1'b1;
    tk(h);
    o_scl = 1'b0;
    tk(h / 2);
  endtask : start

  task automatic stop();
    o_sda_low = 1'b1;
    tk(h / 2);
    o_scl = 1'b1;
    tk(h);
    o_sda_low = 1'b0;
    tk(h);
  endtask : stop

  // Pointer byte then one or two data bytes, high half first
  task automatic wr(input logic [7:0] p, input int n, input logic [15:0] d);
    logic [7:0] r;
    logic       a;
    start();
    xfer(adr, 1'b1, r, a);
    if (a) begin
      xfer(p, 1'b1, r, a);
      if (n == 2) xfer(d[15:8], 1'b1, r, a);
      xfer(d[7:0], 1'b1, r, a);
    end else nacks++;
    stop();
  endtask : wr

  // Pointer write, repeated start, reads; last byte answered with a NACK
  task automatic rd(input logic [7:0] p, input int n, output logic [15:0] v);
    logic [7:0] r;
    logic       a;
    v = 16'h0000;
    start();
    xfer(ADDR_WR, 1'b1, r, a);
    xfer(p, 1'b1, r, a);
    start();
    xfer(ADDR_RD, 1'b1, r, a);
    for (int i = 0; i < n; i++) begin
      xfer(8'hFF, i == n - 1, r, a);
      v = {v[7:0], r};
    end
    stop();
  endtask : rd
endmodule : cbu_host_model
`default_nettype wire

// >>> sim/test_config_block_update.sv
`timescale 1ns/10ps
`default_nettype none
module test_config_block_update import cbu_pkg::*;;
  localparam int DLY = 100;
  logic        i_ref_clk, i_rst, scl, sda_low, sda_oe, sda_out;
  wire logic   sda_w;
  int          mismatches = 0, checks = 0, cyc = 0;
  logic [15:0] v;
  logic [7:0]  ck;
  logic [31:0] tbl [4] = '{32'h3E53_0000, 32'h3E52_04B0, 32'h3F01_0000,
                           32'h3F00_04B0};

  // Pull-up wins unless someone pulls low
  assign sda_w = ~(sda_low | sda_oe);

  cbu_config_block #(.P_CFG_DLY_CYC(DLY)) u_cbu_config_block (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda_w),
    .o_sda(sda_out), .o_sda_oe(sda_oe));
  cbu_host_model u_cbu_host_model (
    .i_ref_clk(i_ref_clk), .i_sda(sda_w), .o_scl(scl), .o_sda_low(sda_low));

  initial begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] p, input int n, input logic [15:0] d);
    u_cbu_host_model.wr(p, n, d);
  endtask : wr

  // Control reads come back low byte first: {low, high}
  task automatic rc(input string nm, input logic [7:0] p, input int n,
                    input logic [15:0] e);
    u_cbu_host_model.rd(p, n, v);
    chk(nm, e, v);
  endtask : rc

  // Update flag is bit 4 of the low flags byte, so v[12]
  task automatic poll(input logic want);
    v[12] = ~want;
    for (int i = 0; i < 8 && v[12] !== want; i++) u_cbu_host_model.rd(8'h06, 2, v);
    chk("update flag", {3'h0, want, 12'h000}, v);
  endtask : poll

  // Hang guard, well above the expected run length
  always @(negedge i_ref_clk) begin
    cyc++;
    if (cyc == 90000) begin
      mismatches++;
      finish_test();
    end
  end

  initial begin
    i_rst = 1'b1;
    repeat (20) @(negedge i_ref_clk);
    i_rst = 1'b0;
    repeat (1200) @(negedge i_ref_clk);
    u_cbu_host_model.adr = 8'h54;
    wr(8'h61, 1, 16'h0000);
    u_cbu_host_model.adr = ADDR_WR;
    rc("locked status", 8'h00, 2, 16'h0020);
    rc("flags idle", 8'h06, 2, 16'h0000);
    wr(8'h00, 2, 16'h1300);
    wr(8'h61, 1, 16'h0000);
    wr(8'h40, 1, 16'h0055);
    rc("enter refused", 8'h00, 2, 16'h0020);
    wr(8'h00, 2, 16'h0080);
    wr(8'h3E, 1, 16'h0001);
    wr(8'h00, 2, 16'h0080);
    rc("broken key", 8'h00, 2, 16'h0020);
    // Stray byte drops the half key left over, so both keys below count
    wr(8'h3E, 1, 16'h0001);
    repeat (2) begin
      wr(8'h00, 1, 16'h0000);
      wr(8'h01, 1, 16'h0080);
    end
    rc("unlocked", 8'h00, 2, 16'h0000);
    wr(8'h00, 2, 16'h1300);
    rc("update status", 8'h00, 2, 16'h2000);
    poll(1'b1);
    wr(8'h61, 1, 16'h0000);
    wr(8'h3E, 1, 16'h0052);
    wr(8'h3F, 1, 16'h0000);
    rc("window clean", 8'h40, 2, 16'h0000);
    rc("checksum blank", 8'h60, 2, 16'hFF00);
    wr(8'h4A, 2, 16'h04B0);
    rc("window value", 8'h4A, 2, 16'h04B0);
    rc("checksum edit", 8'h60, 1, 16'h004B);
    wr(8'h60, 1, 16'h0000);
    rc("edits dropped", 8'h4A, 2, 16'h0000);
    wr(8'h4A, 2, 16'h04B0);
    ck = 8'hFF - (8'hFF - 8'hFF - 8'h00 - 8'h00 + 8'h04 + 8'hB0);
    wr(8'h60, 1, {8'h00, ck});
    // Other places must stay blank, the committed block must come back
    foreach (tbl[i]) begin
      wr(tbl[i][31:24], 1, {8'h00, tbl[i][23:16]});
      rc("selected block", 8'h4A, 2, tbl[i][15:0]);
    end
    rc("selection", 8'h3E, 2, 16'h5200);
    wr(8'h5F, 1, 16'h0077);
    rc("window top", 8'h5F, 1, 16'h0077);
    u_cbu_host_model.h = 20;
    wr(8'h00, 2, 16'h4200);
    rc("update left", 8'h00, 2, 16'h0000);
    poll(1'b0);
    u_cbu_host_model.h = 12;
    wr(8'h00, 2, 16'h2000);
    rc("relocked", 8'h00, 2, 16'h0020);
    wr(8'h4A, 1, 16'h0011);
    rc("locked window", 8'h4A, 2, 16'h04B0);
    chk("address refusals", 16'h0001, 16'(u_cbu_host_model.nacks));
    finish_test();
  end
endmodule : test_config_block_update
`default_nettype wire
